// ### design/pfs_sequencer.sv
// Purpose: Jump, call, return and wait execution for a stored-program interpreter.
// Assumes: One instruction offered per cycle with instr_valid_in; it is taken only while done_out is low.
// Notes:   Other opcodes are executed elsewhere; this block only advances past them when asked.
`timescale 1ns/1ps
`default_nettype none
module pfs_sequencer
(
  input  wire logic                       clk_in,          // 100 MHz clock
  input  wire logic                       reset_n_in,      // Synchronous reset, active low
  input  wire logic                       instr_valid_in,  // Instruction at pc_out is present
  input  wire pfs_pkg::pfs_instr_s        instr_in,        // Fetched instruction fields
  input  wire logic [31:0]                accu_in,         // Accumulator contents
  input  wire pfs_pkg::pfs_axis_s [5:0]   axis_in,         // Per-axis status
  input  wire logic                       clear_error_in,  // Clear-error instruction pulse
  output logic [pfs_pkg::PC_W-1:0]        pc_out,          // Program counter
  output logic                            done_out,        // Instruction retired pulse
  output logic                            waiting_out,     // Wait in progress
  output logic                            timeout_error_flag_out, // Sticky timeout flag
  output logic [3:0]                      depth_out        // Stack occupancy
);
  // ==========================================================================
  // Types and state
  // ==========================================================================
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} pfs_state_e;

  pfs_state_e                 state_r, state_nxt;
  logic [pfs_pkg::PC_W-1:0]   pc_r, pc_nxt;
  logic [pfs_pkg::PC_W-1:0]   stack_r [pfs_pkg::STACK_DEPTH];
  logic [pfs_pkg::PC_W-1:0]   stack_nxt [pfs_pkg::STACK_DEPTH];
  logic [3:0]                 depth_r, depth_nxt;
  logic [31:0]                limit_r, limit_nxt;
  logic [31:0]                ticks_r, ticks_nxt;
  logic [31:0]                presc_r, presc_nxt;
  logic [7:0]                 wtype_r, wtype_nxt;
  logic [2:0]                 axis_sel_r, axis_sel_nxt;
  logic                       done_r, done_nxt;
  logic                       err_r, err_nxt;
  logic                       tick;
  logic                       event_hit;
  logic                       timed_out;
  logic                       waiting_r, waiting_nxt;
  logic [pfs_pkg::PC_W-1:0]   ret_addr;

  // Picks the event of one axis for a given wait type.
  function automatic logic pfs_axis_event(input pfs_pkg::pfs_axis_s a, input logic [7:0] t);
    logic r;
    r = 1'b0;
    unique case (t)
      pfs_pkg::WT_POS:         r = a.target_reached;
      pfs_pkg::WT_HOME_SW:     r = a.home_switch;
      pfs_pkg::WT_END_SW:      r = a.end_switch_left | a.end_switch_right;
      pfs_pkg::WT_HOMING_DONE: r = a.homing_done;
      default:                 r = 1'b0;
    endcase
    return r;
  endfunction : pfs_axis_event

  // ==========================================================================
  // Tick timer
  // ==========================================================================
  // The prescaler restarts with every wait so the first tick is a full period.
  assign tick      = (presc_r == 32'(pfs_pkg::TICK_CYCLES - 1));
  assign event_hit = (wtype_r != pfs_pkg::WT_TICKS) &&
                     (axis_sel_r < 3'(pfs_pkg::NUM_AXES)) &&
                     pfs_axis_event(axis_in[axis_sel_r], wtype_r);
  // Tick waits end on the count; axis waits time out only with a nonzero limit.
  assign timed_out = tick && (ticks_r + 32'h1 >= limit_r) &&
                     ((wtype_r == pfs_pkg::WT_TICKS) || (limit_r != 32'h0));
  // The stack keeps the address of the call itself, so execution resumes one word later.
  assign ret_addr  = stack_r[3'(depth_r - 4'h1)] + 16'h1;

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb
  begin
    state_nxt    = state_r;
    pc_nxt       = pc_r;
    stack_nxt    = stack_r;
    depth_nxt    = depth_r;
    limit_nxt    = limit_r;
    ticks_nxt    = ticks_r;
    presc_nxt    = presc_r;
    wtype_nxt    = wtype_r;
    axis_sel_nxt = axis_sel_r;
    done_nxt     = 1'b0;
    err_nxt      = err_r;
    if (clear_error_in)
      err_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        if (instr_valid_in && !done_r)
        begin
          done_nxt = 1'b1;
          pc_nxt   = pc_r + 16'h1;
          unique case (instr_in.opcode)
            pfs_pkg::OP_JUMP:
              pc_nxt = instr_in.value[pfs_pkg::PC_W-1:0];
            pfs_pkg::OP_CALL:
            begin
              if (depth_r < 4'(pfs_pkg::STACK_DEPTH))
              begin
                stack_nxt[depth_r[2:0]] = pc_r;
                depth_nxt = depth_r + 4'h1;
                pc_nxt    = instr_in.value[pfs_pkg::PC_W-1:0];
              end
              else
                pc_nxt = pc_r;
            end
            pfs_pkg::OP_RETURN:
            begin
              if (depth_r != 4'h0)
              begin
                depth_nxt = depth_r - 4'h1;
                pc_nxt    = ret_addr;
              end
              else
                pc_nxt = pc_r;
            end
            pfs_pkg::OP_WAIT:
            begin
              // Type codes above four are treated as an immediate continue.
              if (instr_in.wtype <= pfs_pkg::WT_HOMING_DONE)
              begin
                done_nxt     = 1'b0;
                pc_nxt       = pc_r;
                state_nxt    = ST_WAIT;
                wtype_nxt    = instr_in.wtype;
                axis_sel_nxt = instr_in.motor[2:0];
                limit_nxt    = (instr_in.value == pfs_pkg::VAL_USE_ACCU) ? accu_in
                                                                          : instr_in.value;
                ticks_nxt    = 32'h0;
                presc_nxt    = 32'h0;
              end
            end
            default:
            begin
            end
          endcase
        end
      end
      ST_WAIT:
      begin
        presc_nxt = tick ? 32'h0 : presc_r + 32'h1;
        if (tick)
          ticks_nxt = ticks_r + 32'h1;
        // A zero tick count ends at once; events take priority over timeout.
        if (event_hit || ((wtype_r == pfs_pkg::WT_TICKS) && limit_r == 32'h0))
        begin
          state_nxt = ST_IDLE;
          pc_nxt    = pc_r + 16'h1;
          done_nxt  = 1'b1;
        end
        else if (timed_out)
        begin
          state_nxt = ST_IDLE;
          pc_nxt    = pc_r + 16'h1;
          done_nxt  = 1'b1;
          if (wtype_r != pfs_pkg::WT_TICKS)
            err_nxt = 1'b1;
        end
      end
    endcase
    // Registered so the wait level leaves the block straight from a flop.
    waiting_nxt = (state_nxt == ST_WAIT);
  end

  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      state_r    <= ST_IDLE;
      pc_r       <= pfs_pkg::PC_RESET;
      depth_r    <= 4'h0;
      limit_r    <= 32'h0;
      ticks_r    <= 32'h0;
      presc_r    <= 32'h0;
      wtype_r    <= 8'h00;
      axis_sel_r <= 3'h0;
      done_r     <= 1'b0;
      err_r      <= 1'b0;
      waiting_r  <= 1'b0;
      for (int i = 0; i < pfs_pkg::STACK_DEPTH; i++)
        stack_r[i] <= 16'h0000;
    end
    else
    begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      depth_r    <= depth_nxt;
      limit_r    <= limit_nxt;
      ticks_r    <= ticks_nxt;
      presc_r    <= presc_nxt;
      wtype_r    <= wtype_nxt;
      axis_sel_r <= axis_sel_nxt;
      done_r     <= done_nxt;
      err_r      <= err_nxt;
      waiting_r  <= waiting_nxt;
      stack_r    <= stack_nxt;
    end
  end

  assign pc_out                 = pc_r;
  assign done_out               = done_r;
  assign waiting_out            = waiting_r;
  assign timeout_error_flag_out = err_r;
  assign depth_out              = depth_r;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_jump_loads_pc: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_JUMP
    |=> pc_r == $past(instr_in.value[15:0]) && done_r)
    else $error("Jump did not load the program counter.");
  a_call_push: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_CALL && depth_r < 4'h8
    |=> depth_r == $past(depth_r) + 4'h1 && pc_r == $past(instr_in.value[15:0]))
    else $error("Call did not push and branch.");
  a_stack_bound: assert property (depth_r <= 4'h8)
    else $error("Return stack exceeded eight entries.");
  a_call_full: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_CALL && depth_r == 4'h8
    |=> depth_r == 4'h8 && $stable(pc_r))
    else $error("Call on full stack had an effect.");
  a_return_pop: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_RETURN && depth_r != 4'h0
    |=> depth_r == $past(depth_r) - 4'h1)
    else $error("Return did not pop.");
  a_return_empty: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_RETURN && depth_r == 4'h0
    |=> depth_r == 4'h0 && $stable(pc_r))
    else $error("Return on empty stack had an effect.");
  a_wait_holds_pc: assert property (state_r == ST_WAIT && $past(state_r) == ST_WAIT |-> $stable(pc_r))
    else $error("Program counter moved during a wait.");
  a_timeout_sets: assert property (
    state_r == ST_WAIT && timed_out && !event_hit && wtype_r != pfs_pkg::WT_TICKS
    |=> timeout_error_flag_out && state_r == ST_IDLE)
    else $error("Timeout did not set the error flag.");
  a_flag_sticky: assert property (err_r && !clear_error_in |=> err_r)
    else $error("Timeout flag cleared without clear-error.");

  a_return_target: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_RETURN && depth_r != 4'h0
    |=> pc_r == $past(ret_addr) && done_r)
    else $error("Return did not resume after the saved call.");
  a_wait_enter: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_WAIT &&
    instr_in.wtype <= pfs_pkg::WT_HOMING_DONE
    |=> waiting_out && !done_r && $stable(pc_r))
    else $error("Wait did not hold the program counter.");
  a_accu_limit: assert property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_WAIT &&
    instr_in.wtype <= pfs_pkg::WT_HOMING_DONE && instr_in.value == pfs_pkg::VAL_USE_ACCU
    |=> limit_r == $past(accu_in))
    else $error("Wait did not take the accumulator as its limit.");
  a_event_ends: assert property (
    state_r == ST_WAIT && event_hit
    |=> state_r == ST_IDLE && done_r && pc_r == $past(pc_r) + 16'h1)
    else $error("Axis event did not end the wait.");
  a_untimed_wait: assert property (
    state_r == ST_WAIT && wtype_r != pfs_pkg::WT_TICKS && limit_r == 32'h0 && !event_hit
    |=> state_r == ST_WAIT)
    else $error("Wait without timeout ended with no event.");
  a_tick_no_flag: assert property (
    state_r == ST_WAIT && wtype_r == pfs_pkg::WT_TICKS && !err_r |=> !err_r)
    else $error("Tick wait set the timeout flag.");
  a_waiting_level: assert property (waiting_out == (state_r == ST_WAIT))
    else $error("Waiting output disagrees with the wait state.");
  a_axis_range: assert property (axis_sel_r >= 3'h6 |-> !event_hit)
    else $error("An axis that does not exist ended a wait.");
  a_tick_period: assert property (state_r == ST_WAIT && tick |=> presc_r == 32'h0)
    else $error("Tick prescaler did not restart after a tick.");

  c_call_nest: cover property (depth_r == 4'h8);
  c_event_end: cover property (state_r == ST_WAIT && event_hit);
  c_timeout: cover property ($rose(err_r));
  c_return_empty: cover property (
    state_r == ST_IDLE && instr_valid_in && !done_r && instr_in.opcode == pfs_pkg::OP_RETURN && depth_r == 4'h0);
  c_tick_wait_end: cover property (
    state_r == ST_WAIT && wtype_r == pfs_pkg::WT_TICKS ##1 done_r);
endmodule : pfs_sequencer
`default_nettype wire

// ### design/pfs_pkg.sv
// Purpose: Shared constants and types for the program-flow sequencer.
// Assumes: 100 MHz clock, 32-bit value field, 8-bit opcode/type/motor fields.
// Notes:   Tick period is derived from the clock rate.
`default_nettype none
package pfs_pkg;
  localparam int          CLK_MHZ        = 100;
  localparam int          TICK_MS        = 10;
  localparam int          TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
  localparam int          STACK_DEPTH    = 8;
  localparam int          PC_W           = 16;
  localparam int          NUM_AXES       = 6;
  localparam logic [7:0]  OP_JUMP        = 8'h16;
  localparam logic [7:0]  OP_CALL        = 8'h17;
  localparam logic [7:0]  OP_RETURN      = 8'h18;
  localparam logic [7:0]  OP_WAIT        = 8'h1b;
  localparam logic [7:0]  WT_TICKS       = 8'h00;
  localparam logic [7:0]  WT_POS         = 8'h01;
  localparam logic [7:0]  WT_HOME_SW     = 8'h02;
  localparam logic [7:0]  WT_END_SW      = 8'h03;
  localparam logic [7:0]  WT_HOMING_DONE = 8'h04;
  localparam logic [31:0] VAL_USE_ACCU   = 32'hffffffff;
  localparam logic [PC_W-1:0] PC_RESET   = 16'h0000;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  wtype;
    logic [7:0]  motor;
    logic [31:0] value;
  } pfs_instr_s;

  typedef struct packed {
    logic target_reached;
    logic home_switch;
    logic end_switch_left;
    logic end_switch_right;
    logic homing_done;
  } pfs_axis_s;
endpackage : pfs_pkg
`default_nettype wire

// ### dv/pfs_prog_mem.sv
// Purpose: Program memory partner that feeds the sequencer one word per address.
// Assumes: The word at the program counter appears combinationally.
// Notes:   The bench fills words and gates fetching with run_in.
`timescale 1ns/1ps
`default_nettype none
module pfs_prog_mem
(
  input  wire logic [pfs_pkg::PC_W-1:0] pc_in,     // Fetch address
  input  wire logic                     run_in,    // Stored program running
  output logic                          valid_out, // Instruction present
  output var pfs_pkg::pfs_instr_s       instr_out  // Fetched word
);
  // ==========================================================================
  // Storage
  pfs_pkg::pfs_instr_s mem [0:255];
  // Only a running stored program offers flow instructions.
  assign valid_out = run_in;
  assign instr_out = mem[pc_in[7:0]];
endmodule : pfs_prog_mem
`default_nettype wire

// ### dv/program_flow_sequencer_tb.sv
// Purpose: Self-checking bench for the program-flow sequencer.
// Assumes: Inputs change on the falling edge; one instruction runs at a time.
// Notes:   A tick lasts a million cycles, so only zero-length tick waits are run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin n_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module program_flow_sequencer_tb;
  // ==========================================================================
  // Harness
  logic                     clk_in;
  logic                     reset_n_in;
  logic                     run;
  logic                     valid;
  logic                     clear_error;
  logic                     done;
  logic                     waiting;
  logic                     tflag;
  logic [3:0]               depth;
  logic [31:0]              accu;
  logic [pfs_pkg::PC_W-1:0] pc;
  pfs_pkg::pfs_instr_s      instr;
  pfs_pkg::pfs_axis_s [5:0] axis;
  int                       errors = 0;
  int                       n_checks = 0;
  int                       cyc = 0;

  pfs_prog_mem pm (.pc_in(pc), .run_in(run), .valid_out(valid), .instr_out(instr));
  pfs_sequencer uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .instr_valid_in(valid), .instr_in(instr),
    .accu_in(accu), .axis_in(axis), .clear_error_in(clear_error), .pc_out(pc), .done_out(done),
    .waiting_out(waiting), .timeout_error_flag_out(tflag), .depth_out(depth));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // The whole run needs well under a thousand cycles; a hang stops here.
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic issue(input logic [7:0] op, input logic [7:0] wt, input logic [7:0] mot, input logic [31:0] val);
    pm.mem[pc[7:0]] = '{op, wt, mot, val};
    run = 1'b1;
    @(negedge clk_in);
  endtask : issue

  // Lets one idle edge pass after retirement so the next take is legal.
  task automatic finish(input int lim);
    int k;
    for (k = 0; k < lim && done !== 1'b1; k++)
      @(negedge clk_in);
    run = 1'b0;
    `CHK("done_out", 1'b1, done)
    @(negedge clk_in);
  endtask : finish

  task automatic go(input logic [7:0] op, input logic [31:0] val);
    issue(op, 8'h07, 8'h05, val);
    finish(4);
  endtask : go

  task automatic t_stack();
    logic [15:0] q[$];
    logic [15:0] exp_pc;
    int          i;
    for (i = 0; i < 8; i++)
    begin
      q.push_back(pc);
      go(pfs_pkg::OP_CALL, 32'h20 + i);
      `CHK("pc_out", 16'h0020 + 16'(i), pc)
      `CHK("depth_out", 4'(i + 1), depth)
    end
    exp_pc = pc;
    go(pfs_pkg::OP_CALL, 32'h00000050);
    `CHK("pc_out", exp_pc, pc)
    `CHK("depth_out", 4'h8, depth)
    for (i = 7; i >= 0; i--)
    begin
      exp_pc = q.pop_back() + 16'h0001;
      go(pfs_pkg::OP_RETURN, 32'h00000000);
      `CHK("pc_out", exp_pc, pc)
      `CHK("depth_out", 4'(i), depth)
    end
    exp_pc = pc;
    go(pfs_pkg::OP_RETURN, 32'h00000000);
    `CHK("pc_out", exp_pc, pc)
    `CHK("depth_out", 4'h0, depth)
  endtask : t_stack

  task automatic t_wait();
    logic [4:0]  ev [1:4];
    logic [15:0] exp_pc;
    int          w;
    ev = '{5'h10, 5'h08, 5'h02, 5'h01};
    for (w = 1; w <= 4; w++)
    begin
      exp_pc = pc;
      issue(pfs_pkg::OP_WAIT, 8'(w), 8'h02, 32'h00000000);
      axis[1] = 5'h1f;
      repeat (6) @(negedge clk_in);
      `CHK("waiting_out", 1'b1, waiting)
      `CHK("pc_out", exp_pc, pc)
      `CHK("done_out", 1'b0, done)
      axis[1] = 5'h00;
      axis[2] = ev[w];
      finish(4);
      `CHK("pc_out", exp_pc + 16'h0001, pc)
      `CHK("waiting_out", 1'b0, waiting)
      axis[2] = 5'h00;
    end
    // Type codes past the last condition must not stall the program.
    exp_pc = pc + 16'h0001;
    issue(pfs_pkg::OP_WAIT, 8'h05, 8'h02, 32'h00000000);
    finish(4);
    `CHK("pc_out", exp_pc, pc)
    `CHK("waiting_out", 1'b0, waiting)
  endtask : t_wait

  task automatic t_ticks();
    logic [15:0] exp_pc;
    exp_pc = pc + 16'h0001;
    issue(pfs_pkg::OP_WAIT, pfs_pkg::WT_TICKS, 8'h04, 32'h00000000);
    finish(4);
    `CHK("pc_out", exp_pc, pc)
    // A non-zero accumulator would stall for millions of cycles.
    accu = 32'h00000000;
    issue(pfs_pkg::OP_WAIT, pfs_pkg::WT_TICKS, 8'h00, pfs_pkg::VAL_USE_ACCU);
    finish(4);
    `CHK("pc_out", exp_pc + 16'h0001, pc)
    `CHK("timeout_error_flag_out", 1'b0, tflag)
    clear_error = 1'b1;
    @(negedge clk_in);
    clear_error = 1'b0;
    @(negedge clk_in);
    `CHK("timeout_error_flag_out", 1'b0, tflag)
  endtask : t_ticks

  initial
  begin
    reset_n_in = 1'b0;
    run = 1'b0;
    clear_error = 1'b0;
    accu = 32'h00000005;
    axis = '0;
    repeat (5) @(negedge clk_in);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    `CHK("depth_out", 4'h0, depth)
    go(pfs_pkg::OP_JUMP, 32'h0000000a);
    `CHK("pc_out", 16'h000a, pc)
    t_stack();
    t_wait();
    t_ticks();
    end_sim();
  end
endmodule : program_flow_sequencer_tb
`default_nettype wire
